// File: include/fault_flags_pkg.sv
// Purpose: shared constants for the device fault status flag block
// Assumes: 100 MHz ref_clk, byte wide status registers
// Notes: Overview below lists the behaviour kept by the block
//
// Overview of operation
// [R1] Buffer supply overvoltage monitor high sets the buffer over flag.
// [R2] Any supply fault present reloads the one shared recovery timer.
// [R3] With no supply fault the timer counts down to zero and stays.
// [R4] Timer nonzero mutes responses; clearing depends on protocol and report disable.
// [R5] With no supply fault, supply register clears after being read twice.
// [R6] Analog regulator out of window sets the analog regulator fault.
// [R7] Digital regulator out of window sets the digital regulator fault.
// [R8] Memory array regulator out of window sets its fault flag.
// [R9] Perimeter loop break sets the perimeter break flag, reset value zero.
// [R10] Memory/temperature status at 0x03 with bits 7,6,5,4,2, reset zero.
// [R11] Factory memory array fault sets the factory memory flag.
// [R12] User memory array fault sets the user memory flag.
// [R13] After init lock, check code over user registers mismatching sets a flag.
// [R14] Memory/temp flags clear on register read or on reporting transmission.
// [R15] Write busy follows an active user programming operation.
// [R16] Over or under temperature sets the temperature range fault.
// [R17] Comm status at 0x04, training fault in bit 6, others read zero.
// [R18] Training settings or master timing error sets the training fault.
// [R19] Training fault clears on read or transmission once condition gone.
// [R20] Memory/temp summary is OR of the five memory/temp flags.
// [R21] A fault still present when cleared keeps its flag set.
// [R22] Reserved bits read zero; writes never change status registers.
package fault_flags_pkg;
    localparam logic [7:0] ADDR_SUPPLY_STATUS = 8'h02;
    localparam logic [7:0] ADDR_MEM_TEMP = 8'h03;
    localparam logic [7:0] ADDR_COMM_STATUS = 8'h04;
    // supply register bit positions
    localparam int BIT_BUF_UNDER = 7;
    localparam int BIT_BUS_UNDER = 6;
    localparam int BIT_BUF_OVER = 5;
    localparam int BIT_ANALOG_REG = 3;
    localparam int BIT_DIGITAL_REG = 2;
    localparam int BIT_NVM_REG = 1;
    localparam int BIT_PERIMETER = 0;
    // memory/temperature register bit positions, then the comm training bit
    localparam int BIT_FACTORY_NVM = 7;
    localparam int BIT_USER_NVM = 6;
    localparam int BIT_CHECK_CODE = 5;
    localparam int BIT_WRITE_BUSY = 4;
    localparam int BIT_TEMP_RANGE = 2;
    localparam int BIT_OSC_TRAIN = 6;
    localparam logic [7:0] SUPPLY_VALID_MASK = 8'hef;
    localparam logic [7:0] MEM_TEMP_VALID_MASK = 8'hf4;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [2:0] PROTO_DSI3_A = 3'h0;
    localparam logic [2:0] PROTO_DSI3_B = 3'h3;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SUPPLY_RECOVERY_TIME_US = 1000;
    localparam int SUPPLY_RECOVERY_CYCLES = (SUPPLY_RECOVERY_TIME_US * 1000) / CLK_PERIOD_NS;
endpackage

// File: include/flag_link_if.sv
// Purpose: link between the flag top and its timer and check helpers
// Assumes: single ref_clk domain
// Notes: levels only, no handshakes
`timescale 1ns/100ps
interface flag_link_if;
    logic faultAny;
    logic timerZero;
    logic lockOn;
    logic codeMismatch;
    modport top_mp (output faultAny, output lockOn, input timerZero, input codeMismatch);
    modport timer_mp (input faultAny, output timerZero);
    modport check_mp (input lockOn, output codeMismatch);
endinterface

// File: rtl/device_fault_status_flags.sv
// Purpose: sticky supply, memory/temperature and communication status flags
// Assumes: monitors and strobes synchronous to ref_clk; read strobe is one cycle
// Notes: read data appears one cycle after the strobe, showing pre-clear values
`timescale 1ns/100ps
module device_fault_status_flags import fault_flags_pkg::*; #(
    parameter int RECOVERY_CYCLES = SUPPLY_RECOVERY_CYCLES,
    parameter int REG_BITS = 64
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic bufUnderMon,
    input wire logic busUnderMon,
    input wire logic bufOverMon,
    input wire logic analogRegMon,
    input wire logic digitalRegMon,
    input wire logic nvmRegMon,
    input wire logic perimeterBreakMon,
    input wire logic factoryNvmMon,
    input wire logic userNvmMon,
    input wire logic writeBusyMon,
    input wire logic tempRangeMon,
    input wire logic oscTrainMon,
    input wire logic supplyReportDisable,
    input wire logic [2:0] protocolSelect,
    input wire logic initDoneLock,
    input wire logic [REG_BITS-1:0] userRegs,
    input wire logic [7:0] storedCode,
    input wire logic regRdStb,
    input wire logic regWrStb,
    input wire logic [7:0] regAddr,
    input wire logic statusTxStb,
    input wire logic [7:0] statusTxAddr,
    output logic [7:0] rdData,
    output logic rdValid,
    output logic respInhibit,
    output logic memoryTempSummary,
    output logic supplySummary,
    output logic commSummary
);
    initial begin
        if (RECOVERY_CYCLES < 1) $error("recovery count must be positive");
    end

    function automatic logic isDsi3(input logic [2:0] p);
        return (p == PROTO_DSI3_A) || (p == PROTO_DSI3_B);
    endfunction

    // clear request for one register: read of it, or a transmission reporting it
    function automatic logic hitReg(input logic stb, input logic [7:0] a, input logic [7:0] target);
        return stb && (a == target);
    endfunction

    flag_link_if link ();

    recovery_timer #(
        .RELOAD(RECOVERY_CYCLES)
    ) u_timer (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .link(link.timer_mp)
    );

    register_check #(
        .REG_BITS(REG_BITS)
    ) u_check (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .userRegs(userRegs),
        .storedCode(storedCode),
        .link(link.check_mp)
    );

    logic [7:0] supplyFlags;
    logic [7:0] memFlags;
    logic oscFlag;
    logic supplyReadSeen;

    // writes are decoded only to be dropped: every register here is read only
    wire logic readOnly = !regWrStb; // R22
    wire logic rdSupply = readOnly && hitReg(regRdStb, regAddr, ADDR_SUPPLY_STATUS);
    wire logic rdMem = readOnly && hitReg(regRdStb, regAddr, ADDR_MEM_TEMP);
    wire logic rdComm = readOnly && hitReg(regRdStb, regAddr, ADDR_COMM_STATUS);
    wire logic txSupply = hitReg(statusTxStb, statusTxAddr, ADDR_SUPPLY_STATUS);
    wire logic txMem = hitReg(statusTxStb, statusTxAddr, ADDR_MEM_TEMP);
    wire logic txComm = hitReg(statusTxStb, statusTxAddr, ADDR_COMM_STATUS);

    // supply monitors in register order, reserved bit tied low
    wire logic [7:0] supplyMon = {
        bufUnderMon,
        busUnderMon,
        bufOverMon, // R1
        1'b0,
        analogRegMon, // R6
        digitalRegMon, // R7
        nvmRegMon, // R8
        perimeterBreakMon // R9
    } & SUPPLY_VALID_MASK;

    wire logic supplyFaultNow = |supplyMon;
    assign link.faultAny = supplyFaultNow; // R2
    assign link.lockOn = initDoneLock; // R13

    // either DSI3 protocol code (0 or 3) with reporting on: clear by read/transmission at timer zero
    wire logic readClearMode = isDsi3(protocolSelect) && !supplyReportDisable; // R4
    // a read clears only if one already happened with no fault in between
    wire logic secondRead = rdSupply && supplyReadSeen; // R5
    wire logic supplyClr = link.timerZero && !supplyFaultNow &&
        (readClearMode ? (txSupply || secondRead) : 1'b1); // R4
    // set over clear keeps a live fault visible
    wire logic [7:0] next_supplyFlags = supplyMon | (supplyFlags & ~{8{supplyClr}}); // R21
    wire logic next_supplyReadSeen = supplyFaultNow ? 1'b0 :
        (supplyClr ? 1'b0 : (supplyReadSeen || rdSupply)); // R5

    wire logic [7:0] memMon = {
        factoryNvmMon, // R11
        userNvmMon, // R12
        link.codeMismatch, // R13
        1'b0,
        1'b0,
        tempRangeMon, // R16
        2'b00
    };
    wire logic memClr = rdMem || txMem; // R14
    wire logic [7:0] stickyMem = (memMon | (memFlags & ~{8{memClr}})) & MEM_TEMP_VALID_MASK; // R21
    // busy is a live level, not sticky
    wire logic [7:0] next_memFlags = {stickyMem[7:5], writeBusyMon, stickyMem[3:0]}; // R15

    wire logic oscClr = rdComm || txComm; // R19
    wire logic next_oscFlag = oscTrainMon || (oscFlag && !oscClr); // R18

    // read mux, reserved and unmapped bits return zero
    wire logic [7:0] commWord = {1'b0, oscFlag, 6'b000000} ; // R17
    wire logic [7:0] next_rdData = rdSupply ? (supplyFlags & SUPPLY_VALID_MASK) :
        rdMem ? (memFlags & MEM_TEMP_VALID_MASK) : // R10
        rdComm ? commWord : 8'h00; // R22
    wire logic next_rdValid = regRdStb && readOnly;
    wire logic next_respInhibit = !link.timerZero || supplyFaultNow; // R4

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            supplyFlags <= STATUS_RESET;
            memFlags <= STATUS_RESET; // R10
            oscFlag <= 1'b0;
            supplyReadSeen <= 1'b0;
        end else begin
            supplyFlags <= next_supplyFlags;
            memFlags <= next_memFlags;
            oscFlag <= next_oscFlag;
            supplyReadSeen <= next_supplyReadSeen;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdData <= 8'h00;
            rdValid <= 1'b0;
            respInhibit <= 1'b0;
        end else begin
            rdData <= next_rdData;
            rdValid <= next_rdValid;
            respInhibit <= next_respInhibit;
        end
    end

    // summaries registered from next values so they track the flags exactly
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            memoryTempSummary <= 1'b0;
            supplySummary <= 1'b0;
            commSummary <= 1'b0;
        end else begin
            memoryTempSummary <= |next_memFlags; // R20
            supplySummary <= |next_supplyFlags;
            commSummary <= next_oscFlag;
        end
    end

    AST_BUF_OVER_SET: assert property (@(posedge ref_clk) disable iff (!rst_b) // R1
        bufOverMon |=> supplyFlags[BIT_BUF_OVER])
        else $error("buffer over flag missed its monitor");

    AST_TIMER_RELOAD: assert property (@(posedge ref_clk) disable iff (!rst_b) // R2
        supplyFaultNow |=> !link.timerZero)
        else $error("timer not reloaded by supply fault");

    AST_TIMER_HOLD_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_b) // R3
        (link.timerZero && !supplyFaultNow) |=> link.timerZero)
        else $error("timer left zero without a fault");

    AST_TIMER_DOWN: assert property (@(posedge ref_clk) disable iff (!rst_b) // R3
        $fell(supplyFaultNow)
        |-> !link.timerZero)
        else $error("timer expired immediately after fault");

    AST_MUTE_WHILE_TIMER: assert property (@(posedge ref_clk) disable iff (!rst_b) // R4
        !link.timerZero |=> respInhibit)
        else $error("responses not muted while timer runs");

    AST_NO_EARLY_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_b) // R4
        (!link.timerZero && supplyFlags[BIT_PERIMETER]) |=> supplyFlags[BIT_PERIMETER])
        else $error("supply flag cleared before timer expiry");

    AST_AUTO_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_b) // R4
        (!readClearMode && link.timerZero && !supplyFaultNow) |=> supplyFlags == 8'h00)
        else $error("supply flags not cleared at timer zero");

    AST_SINGLE_READ_KEEPS: assert property (@(posedge ref_clk) disable iff (!rst_b) // R5
        (readClearMode && rdSupply && !supplyReadSeen && !txSupply && supplyFlags[BIT_BUF_OVER])
        |=> supplyFlags[BIT_BUF_OVER])
        else $error("supply register cleared on first read");

    AST_PERIMETER_SET: assert property (@(posedge ref_clk) disable iff (!rst_b) // R9
        perimeterBreakMon |=> supplyFlags[BIT_PERIMETER] ##1 supplyFlags[BIT_PERIMETER] || !perimeterBreakMon)
        else $error("perimeter flag missed its monitor");

    AST_CHECK_FAULT: assert property (@(posedge ref_clk) disable iff (!rst_b) // R13
        (initDoneLock && link.codeMismatch) |=> memFlags[BIT_CHECK_CODE])
        else $error("check mismatch not flagged");

    AST_MEM_READ_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_b) // R14
        (rdMem && !tempRangeMon) |=> !memFlags[BIT_TEMP_RANGE] && rdValid)
        else $error("temperature flag survived a clearing read");

    AST_BUSY_TRACK: assert property (@(posedge ref_clk) disable iff (!rst_b) // R15
        ##1 memFlags[BIT_WRITE_BUSY] == $past(writeBusyMon))
        else $error("write busy does not follow programming");

    AST_SUMMARY_OR: assert property (@(posedge ref_clk) disable iff (!rst_b) // R20
        memoryTempSummary == |memFlags)
        else $error("summary differs from memory/temp flags");

    AST_OSC_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_b) // R19
        (oscTrainMon && rdComm)
        |=> oscFlag && rdValid)
        else $error("training flag cleared while condition present");

    AST_COMM_READ: assert property (@(posedge ref_clk) disable iff (!rst_b) // R17
        rdComm |=> rdValid && (rdData[7] == 1'b0) && (rdData[5:0] == 6'h00))
        else $error("comm status reserved bits not zero");

    AST_WRITE_IGNORED: assert property (@(posedge ref_clk) disable iff (!rst_b) // R22
        (regWrStb && !statusTxStb)
        |=> memFlags[7:5] == ($past(memFlags[7:5]) | $past(memMon[7:5])))
        else $error("write disturbed status register");

    AST_ANALOG_SET: assert property (@(posedge ref_clk) disable iff (!rst_b) // R6
        analogRegMon
        |=> supplyFlags[BIT_ANALOG_REG])
        else $error("analog regulator flag missed its monitor");

    AST_DIGITAL_SET: assert property (@(posedge ref_clk) disable iff (!rst_b) // R7
        digitalRegMon
        |=> supplyFlags[BIT_DIGITAL_REG])
        else $error("digital regulator flag missed its monitor");

    AST_NVM_REG_SET: assert property (@(posedge ref_clk) disable iff (!rst_b) // R8
        nvmRegMon
        |=> supplyFlags[BIT_NVM_REG])
        else $error("memory regulator flag missed its monitor");

    AST_FACTORY_SET: assert property (@(posedge ref_clk) disable iff (!rst_b) // R11
        factoryNvmMon
        |=> memFlags[BIT_FACTORY_NVM])
        else $error("factory memory flag missed its monitor");

    AST_USER_SET: assert property (@(posedge ref_clk) disable iff (!rst_b) // R12
        userNvmMon
        |=> memFlags[BIT_USER_NVM])
        else $error("user memory flag missed its monitor");

    AST_TEMP_SET: assert property (@(posedge ref_clk) disable iff (!rst_b) // R16
        tempRangeMon
        |=> memFlags[BIT_TEMP_RANGE])
        else $error("temperature flag missed its monitor");

    AST_OSC_SET: assert property (@(posedge ref_clk) disable iff (!rst_b) // R18
        oscTrainMon
        |=> oscFlag)
        else $error("training flag missed its monitor");

    AST_SECOND_READ_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_b) // R5
        (secondRead && link.timerZero && !supplyFaultNow)
        |=> supplyFlags == 8'h00)
        else $error("supply register kept after second read");

    AST_MEM_TX_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_b) // R14
        (txMem && !factoryNvmMon && !userNvmMon)
        |=> memFlags[7:6] == 2'b00)
        else $error("memory flags survived a reporting transmission");

    AST_OSC_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_b) // R19
        (oscClr && !oscTrainMon)
        |=> !oscFlag)
        else $error("training flag kept after clear with condition gone");

    AST_UNMAPPED_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_b) // R22
        (regRdStb && !rdSupply && !rdMem && !rdComm)
        |=> rdData == 8'h00)
        else $error("unmapped or refused read returned data");

    AST_LOCK_GATE: assert property (@(posedge ref_clk) disable iff (!rst_b) // R13
        !initDoneLock
        |=> !link.codeMismatch)
        else $error("check mismatch raised before init lock");

    AST_MEM_RESERVED: assert property (@(posedge ref_clk) disable iff (!rst_b) // R10
        rdMem
        |=> rdValid && ((rdData & ~MEM_TEMP_VALID_MASK) == 8'h00))
        else $error("memory/temp reserved bits not zero");

    COV_SUPPLY_RECOVERY: cover property (@(posedge ref_clk) disable iff (!rst_b)
        $fell(supplyFaultNow) ##[1:1000] $rose(link.timerZero));
    COV_MEM_CLEAR: cover property (@(posedge ref_clk) disable iff (!rst_b)
        memFlags[BIT_FACTORY_NVM] ##1 rdMem ##1 !memFlags[BIT_FACTORY_NVM]);
    COV_OSC_TX_CLEAR: cover property (@(posedge ref_clk) disable iff (!rst_b)
        oscFlag && txComm && !oscTrainMon);
    COV_SECOND_READ: cover property (@(posedge ref_clk) disable iff (!rst_b)
        secondRead && link.timerZero);
    COV_OSC_LIVE_READ: cover property (@(posedge ref_clk) disable iff (!rst_b)
        oscTrainMon && rdComm);
endmodule // device_fault_status_flags

// File: rtl/recovery_timer.sv
// Purpose: shared supply fault recovery countdown
// Assumes: one tick per ref_clk cycle
// Notes: starts at zero after reset
`timescale 1ns/100ps
module recovery_timer import fault_flags_pkg::*; #(
    parameter int RELOAD = SUPPLY_RECOVERY_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    flag_link_if.timer_mp link
);
    localparam int CW = $clog2(RELOAD + 1);
    initial begin
        if (RELOAD < 1) $error("recovery reload must be at least one cycle");
    end
    logic [CW-1:0] count;
    wire logic [CW-1:0] next_count = link.faultAny ? CW'(RELOAD) : // R2
        ((count == '0) ? count : count - CW'(1)); // R3
    assign link.timerZero = (count == '0);
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) count <= '0;
        else count <= next_count;
    end
endmodule // recovery_timer

// File: rtl/register_check.sv
// Purpose: check code over user writable registers after init lock
// Assumes: stored code computed earlier and held outside
// Notes: xor fold is cheap but misses paired flips in one column
`timescale 1ns/100ps
module register_check import fault_flags_pkg::*; #(
    parameter int REG_BITS = 64
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [REG_BITS-1:0] userRegs,
    input wire logic [7:0] storedCode,
    flag_link_if.check_mp link
);
    initial begin
        if (REG_BITS < 8 || REG_BITS % 8 != 0) $error("user register width must be whole bytes");
    end
    function automatic logic [7:0] foldCode(input logic [REG_BITS-1:0] v);
        logic [7:0] acc;
        acc = 8'h00;
        for (int i = 0; i < REG_BITS / 8; i++) acc = acc ^ v[i*8 +: 8];
        return acc;
    endfunction
    wire logic next_mismatch = link.lockOn && (foldCode(userRegs) != storedCode); // R13
    logic mismatch;
    assign link.codeMismatch = mismatch;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) mismatch <= 1'b0;
        else mismatch <= next_mismatch;
    end
endmodule // register_check

// File: test/status_master.sv
// Purpose: bus master model that reads status registers and sends status reports
// Assumes: drives at the falling edge of ref_clk, answer one cycle after the strobe
// Notes: idle address lines show the inverse of the last value, never a stale copy
`timescale 1ns/100ps
module status_master (
    input wire logic ref_clk,
    input wire logic [7:0] rdData,
    input wire logic rdValid,
    output logic regRdStb,
    output logic regWrStb,
    output logic [7:0] regAddr,
    output logic statusTxStb,
    output logic [7:0] statusTxAddr
);
    initial begin
        regRdStb = 1'b0;
        regWrStb = 1'b0;
        statusTxStb = 1'b0;
        regAddr = 8'h00;
        statusTxAddr = 8'h00;
    end

    task access(input logic [7:0] a, input logic rd, input logic wr, input logic tx,
                output logic [7:0] data, output logic valid);
        @(negedge ref_clk);
        regAddr = a;
        statusTxAddr = a;
        regRdStb = rd;
        regWrStb = wr;
        statusTxStb = tx;
        @(negedge ref_clk);
        data = rdData;
        valid = rdValid;
        regRdStb = 1'b0;
        regWrStb = 1'b0;
        statusTxStb = 1'b0;
        // released lines toggle so a stale address cannot pass for a held one
        regAddr = ~a;
        statusTxAddr = ~a;
    endtask
endmodule // status_master

// File: test/tb_device_fault_status_flags.sv
// Purpose: self-checking bench for the sticky fault status flags
// Assumes: recovery count shortened to 8 cycles
// Notes: table rows cover set and clear per flag except write busy and check code; hand tests cover those and awkward cases
`timescale 1ns/100ps
`define CHK(got, exp) begin nTests++; if ((got) !== (exp)) begin failCount++; \
    $display("Error %0t: got %h expected %h", $time, got, exp); end end
module tb_device_fault_status_flags;
    import fault_flags_pkg::*;
    localparam int RCV = 8;
    typedef struct {int idx; logic [7:0] addr; logic [7:0] e1; logic [7:0] e2; logic [2:0] sum;} row_s;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [11:0] mon = 12'h000;
    logic supplyReportDisable = 1'b0;
    logic [2:0] protocolSelect = 3'h0;
    logic initDoneLock = 1'b0;
    logic [63:0] userRegs = 64'h0102030405060708;
    logic [7:0] storedCode = 8'h55;
    logic regRdStb, regWrStb, statusTxStb, rdValid, respInhibit;
    logic memoryTempSummary, supplySummary, commSummary, rdOk;
    logic [7:0] regAddr, statusTxAddr, rdData, rdVal;
    int failCount = 0;
    int nTests = 0;
    int cycles = 0;
    int n;
    row_s rows[11] = '{'{2, 8'h02, 8'h20, 8'h20, 3'h4}, '{3, 8'h02, 8'h08, 8'h08, 3'h4},
        '{4, 8'h02, 8'h04, 8'h04, 3'h4}, '{5, 8'h02, 8'h02, 8'h02, 3'h4}, '{6, 8'h02, 8'h01, 8'h01, 3'h4},
        '{0, 8'h02, 8'h80, 8'h80, 3'h4}, '{1, 8'h02, 8'h40, 8'h40, 3'h4}, '{7, 8'h03, 8'h80, 8'h00, 3'h2},
        '{8, 8'h03, 8'h40, 8'h00, 3'h2}, '{10, 8'h03, 8'h04, 8'h00, 3'h2}, '{11, 8'h04, 8'h40, 8'h00, 3'h1}};

    always #5 ref_clk = ~ref_clk;

    device_fault_status_flags #(.RECOVERY_CYCLES(RCV), .REG_BITS(64)) dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .bufUnderMon(mon[0]), .busUnderMon(mon[1]),
        .bufOverMon(mon[2]), .analogRegMon(mon[3]), .digitalRegMon(mon[4]), .nvmRegMon(mon[5]),
        .perimeterBreakMon(mon[6]), .factoryNvmMon(mon[7]), .userNvmMon(mon[8]),
        .writeBusyMon(mon[9]), .tempRangeMon(mon[10]), .oscTrainMon(mon[11]),
        .supplyReportDisable(supplyReportDisable), .protocolSelect(protocolSelect),
        .initDoneLock(initDoneLock), .userRegs(userRegs), .storedCode(storedCode),
        .regRdStb(regRdStb), .regWrStb(regWrStb), .regAddr(regAddr), .statusTxStb(statusTxStb),
        .statusTxAddr(statusTxAddr), .rdData(rdData), .rdValid(rdValid), .respInhibit(respInhibit),
        .memoryTempSummary(memoryTempSummary), .supplySummary(supplySummary), .commSummary(commSummary));

    status_master master (.ref_clk(ref_clk), .rdData(rdData), .rdValid(rdValid), .regRdStb(regRdStb),
        .regWrStb(regWrStb), .regAddr(regAddr), .statusTxStb(statusTxStb), .statusTxAddr(statusTxAddr));

    task rd(input logic [7:0] a);
        master.access(a, 1'b1, 1'b0, 1'b0, rdVal, rdOk);
    endtask

    task tx(input logic [7:0] a);
        master.access(a, 1'b0, 1'b0, 1'b1, rdVal, rdOk);
    endtask

    task pulse(input int i);
        @(negedge ref_clk);
        mon[i] = 1'b1;
        @(negedge ref_clk);
        mon[i] = 1'b0;
    endtask

    task complete_run;
        $display("Comparisons %0d mismatches %0d", nTests, failCount);
        if (failCount == 0 && nTests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ceiling well above the few hundred cycles the sequence needs
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failCount++;
            $display("Error %0t: run timed out", $time);
            complete_run();
        end
    end

    initial begin
        repeat (20) @(negedge ref_clk);
        rst_b = 1'b1;
        `CHK({respInhibit, memoryTempSummary, supplySummary, commSummary}, 4'h0)
        rd(8'h03);
        `CHK(rdVal, 8'h00)
        rd(8'h04);
        `CHK({rdOk, rdVal}, 9'h100)
        // stored code mismatches here, so unlocked rows also prove the lock gate
        foreach (rows[i]) begin
            pulse(rows[i].idx);
            `CHK({supplySummary, memoryTempSummary, commSummary}, rows[i].sum)
            repeat (12) @(negedge ref_clk);
            rd(rows[i].addr);
            `CHK(rdVal, rows[i].e1)
            rd(rows[i].addr);
            `CHK(rdVal, rows[i].e2)
            rd(rows[i].addr);
            `CHK(rdVal, 8'h00)
        end
        mon[2] = 1'b1;
        repeat (3) @(negedge ref_clk);
        `CHK(respInhibit, 1'b1)
        mon[2] = 1'b0;
        n = 0;
        while (respInhibit === 1'b1 && n < 50) begin
            @(negedge ref_clk);
            n++;
        end
        `CHK(n >= RCV - 1 && n <= RCV + 2, 1'b1)
        tx(ADDR_SUPPLY_STATUS);
        rd(8'h02);
        `CHK(rdVal, 8'h00)
        protocolSelect = 3'h1;
        pulse(5);
        repeat (12) @(negedge ref_clk);
        rd(8'h02);
        `CHK(rdVal, 8'h00)
        protocolSelect = 3'h3;
        pulse(3);
        repeat (12) @(negedge ref_clk);
        rd(8'h02);
        `CHK(rdVal, 8'h08)
        tx(8'h02);
        rd(8'h02);
        `CHK(rdVal, 8'h00)
        protocolSelect = 3'h0;
        supplyReportDisable = 1'b1;
        pulse(4);
        repeat (12) @(negedge ref_clk);
        rd(8'h02);
        `CHK(rdVal, 8'h00)
        supplyReportDisable = 1'b0;
        mon[10] = 1'b1;
        rd(8'h03);
        rd(8'h03);
        `CHK(rdVal, 8'h04)
        mon[10] = 1'b0;
        rd(8'h03);
        `CHK(rdVal, 8'h04)
        rd(8'h03);
        `CHK(rdVal, 8'h00)
        mon[9] = 1'b1;
        rd(8'h03);
        rd(8'h03);
        `CHK({rdVal, memoryTempSummary}, 9'h021)
        mon[9] = 1'b0;
        repeat (2) @(negedge ref_clk);
        rd(8'h03);
        `CHK(rdVal, 8'h00)
        storedCode = 8'h08;
        initDoneLock = 1'b1;
        repeat (3) @(negedge ref_clk);
        rd(8'h03);
        `CHK(rdVal, 8'h00)
        storedCode = 8'h09;
        repeat (3) @(negedge ref_clk);
        rd(8'h03);
        `CHK(rdVal, 8'h20)
        storedCode = 8'h08;
        rd(8'h03);
        rd(8'h03);
        `CHK(rdVal, 8'h00)
        pulse(7);
        tx(ADDR_MEM_TEMP);
        rd(8'h03);
        `CHK(rdVal, 8'h00)
        pulse(11);
        tx(ADDR_COMM_STATUS);
        rd(8'h04);
        `CHK(rdVal, 8'h00)
        mon[11] = 1'b1;
        rd(8'h04);
        `CHK(rdVal, 8'h40)
        mon[11] = 1'b0;
        rd(8'h04);
        `CHK(rdVal, 8'h40)
        rd(8'h04);
        `CHK(rdVal, 8'h00)
        pulse(8);
        master.access(8'h03, 1'b1, 1'b1, 1'b0, rdVal, rdOk);
        `CHK(rdOk, 1'b0)
        master.access(8'h03, 1'b0, 1'b1, 1'b0, rdVal, rdOk);
        rd(8'h03);
        `CHK(rdVal, 8'h40)
        rd(8'h05);
        `CHK({rdOk, rdVal}, 9'h100)
        pulse(8);
        @(negedge ref_clk);
        rst_b = 1'b0;
        repeat (2) @(negedge ref_clk);
        rst_b = 1'b1;
        rd(8'h03);
        `CHK(rdVal, 8'h00)
        complete_run();
    end
endmodule // tb_device_fault_status_flags
